// >>> include/dlp_cfg.svh
// Purpose: Offsets, field positions, reset values and codes for the distributor low-power block
// Assumes: 32-bit register port, 8-bit byte address, one aligned word per register
// Notes: Types live in dlp_pkg
`ifndef DLP_CFG_SVH
`define DLP_CFG_SVH

`define DLP_OFS_QUIESCENT 8'h00
`define DLP_OFS_WAKE_EN   8'h04
`define DLP_OFS_STATUS    8'h08
`define DLP_OFS_BUS_EN    8'h0C
`define DLP_OFS_MGR       8'h10
`define DLP_OFS_OUTST     8'h14

`define DLP_RST_QUIESCENT 16'h0000
`define DLP_RST_WAKE_EN   16'h0000
`define DLP_RST_MGR       1'h0

`define DLP_BURST_FIXED   2'h0
`define DLP_BURST_INCR    2'h1
`define DLP_BURST_WRAP    2'h2

`define DLP_STAT_CLK_STOP 16
`define DLP_STAT_ISO      17
`define DLP_STAT_CC_ERR   18
`define DLP_STAT_REG_ERR  19
`define DLP_MGR_FIX_WRAP  0

`endif

// >>> include/dlp_pkg.sv
// Purpose: Shared types of the distributor low-power block
// Assumes: Nothing beyond the cfg header
// Notes: Q-Channel handshake states
package dlp_pkg;

  typedef enum logic [1:0] {
    Q_RUN,
    Q_STOP,
    Q_DENY
  } dlp_qstate_t;

  typedef logic [1:0] dlp_burst_t;

endpackage

// >>> rtl/dlp_sync.sv
// Purpose: Two-flop synchroniser for asynchronous request pins
// Assumes: Inputs may change at any time relative to core_clk
// Notes: First stage feeds only the second stage
module dlp_sync #(
  parameter int          W       = 1,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] d_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL[W-1:0];
      d_sync <= RST_VAL[W-1:0];
    end
    else if (ce)
    begin
      meta_q <= d_async;
      d_sync <= meta_q;
    end
  end

endmodule

// >>> rtl/dlp_qchan.sv
// Purpose: One Q-Channel device-side handshake
// Assumes: req_n_s already synchronised to core_clk
// Notes: Answer decision taken once, on the falling request
module dlp_qchan (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  // Channel
  input  wire logic req_n_s,
  input  wire logic allow,
  output logic      accept_n,
  output logic      deny,
  output logic      stopped
);
  dlp_pkg::dlp_qstate_t st_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st_q <= dlp_pkg::Q_RUN;
    else if (ce)
    begin
      unique case (st_q)
        dlp_pkg::Q_RUN:
          if (!req_n_s)
            st_q <= allow ? dlp_pkg::Q_STOP : dlp_pkg::Q_DENY;
        dlp_pkg::Q_STOP:
          if (req_n_s)
            st_q <= dlp_pkg::Q_RUN;
        dlp_pkg::Q_DENY:
          if (req_n_s)
            st_q <= dlp_pkg::Q_RUN;
        // Fourth code is unused; recover to run rather than lock up
        default:
          st_q <= dlp_pkg::Q_RUN;
      endcase
    end
  end

  assign accept_n = (st_q != dlp_pkg::Q_STOP);
  assign deny     = (st_q == dlp_pkg::Q_DENY);
  assign stopped  = (st_q == dlp_pkg::Q_STOP);

  q_one_answer_a: assert property (@(posedge core_clk) disable iff (rst)
    !(deny && !accept_n))
    else $error("accept and deny both asserted");

  q_answer_held_a: assert property (@(posedge core_clk) disable iff (rst)
    (!req_n_s && (deny || !accept_n)) |=> ($stable(deny) && $stable(accept_n)))
    else $error("answer dropped while request low");

  q_answer_given_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && !req_n_s && accept_n && !deny) |=> (deny ^ !accept_n))
    else $error("request low left unanswered");

endmodule

// >>> rtl/dlp_top.sv
// Purpose: Distributor low-power channels and manager port shaping
// Assumes: Manager and unit-bus signals are on core_clk; request pins are asynchronous
// Notes: Wake outputs are combinational from asynchronous inputs
//
// Implementation choices: strobed register access and the register addresses.
`include "dlp_cfg.svh"

module dlp_top #(
  parameter int   N_UNITS    = 4,
  parameter int   ID_W       = 2,
  parameter int   OUT_W      = 4,
  parameter logic CROSS_CHIP = 1'b0,
  parameter logic MULTICHIP  = 1'b0
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_we,
  input  wire logic               reg_re,
  output logic      [31:0]        reg_rdata,
  // Distributor clock Q-Channel
  input  wire logic               dist_qreq_n,
  output logic                    dist_qaccept_n,
  output logic                    dist_qdeny,
  output logic                    dist_clk_en,
  input  wire logic               dist_busy,
  // Unit power Q-Channels and buses
  input  wire logic [N_UNITS-1:0] unit_qreq_n,
  output logic      [N_UNITS-1:0] unit_qaccept_n,
  output logic      [N_UNITS-1:0] unit_qdeny,
  input  wire logic [N_UNITS-1:0] unit_bus_busy,
  output logic      [N_UNITS-1:0] unit_bus_en,
  input  wire logic [N_UNITS-1:0] unit_msg_pending,
  output logic      [N_UNITS-1:0] unit_wake_active,
  // P-Channel
  input  wire logic               p_req,
  input  wire logic               p_state,
  output logic                    p_accept,
  output logic                    p_isolated,
  // Manager request in
  input  wire logic               mreq_valid,
  output logic                    mreq_ready,
  input  wire logic               mreq_write,
  input  wire logic [31:0]        mreq_addr,
  input  wire logic [3:0]         mreq_len,
  input  wire logic [2:0]         mreq_size,
  input  wire logic [1:0]         mreq_burst,
  input  wire logic [ID_W-1:0]    mreq_id,
  input  wire logic               mreq_cc,
  // Manager address out
  output logic                    ax_valid,
  input  wire logic               ax_ready,
  output logic                    ax_write,
  output logic      [31:0]        ax_addr,
  output logic      [3:0]         ax_len,
  output logic      [2:0]         ax_size,
  output logic      [1:0]         ax_burst,
  output logic      [ID_W-1:0]    ax_id,
  // Manager responses
  input  wire logic               r_valid,
  input  wire logic [ID_W-1:0]    r_id,
  input  wire logic               r_last,
  output logic                    r_ready,
  input  wire logic               b_valid,
  input  wire logic [ID_W-1:0]    b_id,
  output logic                    b_ready
);
  localparam int N_IDS = 1 << ID_W;

  if (N_UNITS < 1 || N_UNITS > 16)
    $error("N_UNITS must be 1 to 16");
  if (ID_W < 1 || ID_W > 4 || OUT_W < 2 || OUT_W > 8)
    $error("ID_W or OUT_W out of range");

  logic [N_UNITS-1:0] quiescent_q;
  logic [N_UNITS-1:0] wake_en_q;
  logic               fix_wrap_q;
  logic               cc_err_q;
  logic               reg_err_q;
  logic [N_UNITS-1:0] unit_req_s;
  logic [N_UNITS-1:0] unit_stopped;
  logic               dist_req_s;
  logic               dist_stopped;
  logic [N_IDS-1:0]   id_busy;
  logic               any_outst;
  logic               iso_q;
  logic               pacc_q;
  logic               req_regular;
  logic               req_legal;
  logic               id_room;
  logic               take;
  logic               issue;
  logic [1:0]         burst_d;
  logic [OUT_W-1:0]   outst_cnt [N_IDS];

  dlp_sync #(
    .W       (1),
    .RST_VAL (16'h0001)
  ) u_dist_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .d_async  (dist_qreq_n),
    .d_sync   (dist_req_s)
  );

  dlp_sync #(
    .W       (N_UNITS),
    .RST_VAL (16'hFFFF)
  ) u_unit_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .d_async  (unit_qreq_n),
    .d_sync   (unit_req_s)
  );

  dlp_qchan u_dist_q (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .req_n_s  (dist_req_s),
    .allow    (!dist_busy && !any_outst && !ax_valid),
    .accept_n (dist_qaccept_n),
    .deny     (dist_qdeny),
    .stopped  (dist_stopped)
  );

  assign dist_clk_en = !dist_stopped;

  for (genvar i = 0; i < N_UNITS; i++)
  begin : g_unit
    dlp_qchan u_q (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .req_n_s  (unit_req_s[i]),
      .allow    (quiescent_q[i] && !unit_bus_busy[i]),
      .accept_n (unit_qaccept_n[i]),
      .deny     (unit_qdeny[i]),
      .stopped  (unit_stopped[i])
    );
    assign unit_bus_en[i]      = !unit_stopped[i] && !wake_en_q[i];
    assign unit_wake_active[i] = wake_en_q[i] && unit_msg_pending[i];
  end

  if (MULTICHIP)
  begin : g_pchan
    logic preq_s;
    logic pstate_s;

    dlp_sync #(
      .W       (2),
      .RST_VAL (16'h0000)
    ) u_p_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .d_async  ({p_req, p_state}),
      .d_sync   ({preq_s, pstate_s})
    );

    // Isolation waits for traffic to drain so state saved is complete
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        iso_q  <= 1'b0;
        pacc_q <= 1'b0;
      end
      else if (ce)
      begin
        if (preq_s && !pacc_q && !any_outst && !ax_valid)
        begin
          iso_q  <= pstate_s;
          pacc_q <= 1'b1;
        end
        else if (!preq_s)
          pacc_q <= 1'b0;
      end
    end
  end
  else
  begin : g_no_pchan
    assign iso_q  = 1'b0;
    assign pacc_q = 1'b0;
  end

  assign p_accept   = pacc_q;
  assign p_isolated = iso_q;

  always_comb
  begin
    req_regular = (mreq_len == 4'h0) || (mreq_len == 4'h1) || (mreq_len == 4'h3) ||
                  (mreq_len == 4'h7) || (mreq_len == 4'hF);
    if (mreq_size != 3'h0)
      req_regular = req_regular && ((mreq_addr & ((32'h1 << mreq_size) - 32'h1)) == 32'h0);
    req_legal = CROSS_CHIP ? 1'b1 : (!mreq_cc && req_regular);
  end

  always_comb
  begin
    burst_d = mreq_burst;
    if (mreq_burst == `DLP_BURST_FIXED || mreq_burst == 2'h3)
      burst_d = fix_wrap_q ? `DLP_BURST_WRAP : `DLP_BURST_INCR;
    // Wrap needs a power-of-two length above one beat
    if (burst_d == `DLP_BURST_WRAP && (!req_regular || mreq_len == 4'h0))
      burst_d = `DLP_BURST_INCR;
  end

  assign id_room    = (outst_cnt[mreq_id] != {OUT_W{1'b1}});
  // Cross-chip traffic stalls while isolated rather than being dropped
  assign mreq_ready = ce && (!ax_valid || ax_ready) && id_room && !(iso_q && mreq_cc);
  assign take       = mreq_valid && mreq_ready;
  assign issue      = ax_valid && ax_ready && ce;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ax_valid <= 1'b0;
      ax_write <= 1'b0;
      ax_addr  <= 32'h0000_0000;
      ax_len   <= 4'h0;
      ax_size  <= 3'h0;
      ax_burst <= `DLP_BURST_INCR;
      ax_id    <= '0;
    end
    else if (ce)
    begin
      if (take && req_legal)
      begin
        ax_valid <= 1'b1;
        ax_write <= mreq_write;
        ax_addr  <= mreq_addr;
        ax_len   <= mreq_len;
        ax_size  <= mreq_size;
        ax_burst <= burst_d;
        ax_id    <= mreq_id;
      end
      else if (ax_ready)
        ax_valid <= 1'b0;
    end
  end

  assign r_ready = 1'b1;
  assign b_ready = 1'b1;

  // Counters count at address issue, so a response never beats its count
  for (genvar k = 0; k < N_IDS; k++)
  begin : g_outst
    logic inc;
    logic dec_r;
    logic dec_b;
    assign inc   = issue && (ax_id == ID_W'(k));
    assign dec_r = r_valid && r_last && (r_id == ID_W'(k));
    // A read and a write of one ID may retire together; both must count
    assign dec_b = b_valid && (b_id == ID_W'(k));
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        outst_cnt[k] <= '0;
      else if (ce)
        outst_cnt[k] <= outst_cnt[k] + OUT_W'(inc) - OUT_W'(dec_r) - OUT_W'(dec_b);
    end
    assign id_busy[k] = (outst_cnt[k] != '0);
  end

  assign any_outst = |id_busy;

  // Software-steered registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      quiescent_q <= N_UNITS'(`DLP_RST_QUIESCENT);
      wake_en_q   <= N_UNITS'(`DLP_RST_WAKE_EN);
      fix_wrap_q  <= `DLP_RST_MGR;
    end
    else if (ce && reg_we)
    begin
      unique case (reg_addr)
        `DLP_OFS_QUIESCENT: quiescent_q <= reg_wdata[N_UNITS-1:0];
        `DLP_OFS_WAKE_EN:   wake_en_q   <= reg_wdata[N_UNITS-1:0];
        `DLP_OFS_MGR:       fix_wrap_q  <= reg_wdata[`DLP_MGR_FIX_WRAP];
        default:            ;
      endcase
    end
  end

  // Sticky errors: a new refusal wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cc_err_q  <= 1'b0;
      reg_err_q <= 1'b0;
    end
    else if (ce)
    begin
      if (reg_we && reg_addr == `DLP_OFS_STATUS)
      begin
        if (reg_wdata[`DLP_STAT_CC_ERR])
          cc_err_q <= 1'b0;
        if (reg_wdata[`DLP_STAT_REG_ERR])
          reg_err_q <= 1'b0;
      end
      if (take && !req_legal && mreq_cc)
        cc_err_q <= 1'b1;
      if (take && !req_legal && !mreq_cc)
        reg_err_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (ce)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_re)
      begin
        unique case (reg_addr)
          `DLP_OFS_QUIESCENT: reg_rdata[N_UNITS-1:0] <= quiescent_q;
          `DLP_OFS_WAKE_EN:   reg_rdata[N_UNITS-1:0] <= wake_en_q;
          `DLP_OFS_STATUS:
          begin
            reg_rdata[N_UNITS-1:0]          <= unit_stopped;
            reg_rdata[`DLP_STAT_CLK_STOP]   <= dist_stopped;
            reg_rdata[`DLP_STAT_ISO]        <= iso_q;
            reg_rdata[`DLP_STAT_CC_ERR]     <= cc_err_q;
            reg_rdata[`DLP_STAT_REG_ERR]    <= reg_err_q;
          end
          `DLP_OFS_BUS_EN:    reg_rdata[N_UNITS-1:0] <= unit_bus_en;
          `DLP_OFS_MGR:       reg_rdata[`DLP_MGR_FIX_WRAP] <= fix_wrap_q;
          `DLP_OFS_OUTST:     reg_rdata[N_IDS-1:0] <= id_busy;
          default:            ;
        endcase
      end
    end
  end

  no_fixed_burst_a: assert property (@(posedge core_clk) disable iff (rst)
    ax_valid |-> (ax_burst == `DLP_BURST_INCR || ax_burst == `DLP_BURST_WRAP))
    else $error("fixed burst issued");

  read_beats_taken_a: assert property (@(posedge core_clk) disable iff (rst)
    (r_valid && r_last && ce && !(issue && ax_id == r_id) && !(b_valid && b_id == r_id) &&
     outst_cnt[r_id] != '0)
    |=> (outst_cnt[$past(r_id)] == $past(outst_cnt[r_id]) - 1'b1))
    else $error("interleaved read last not retired");

  regular_only_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && take && !CROSS_CHIP && (mreq_cc || !req_regular)) |=> !ax_valid || $stable(ax_addr))
    else $error("irregular or cross-chip request issued");

  clk_deny_busy_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && dist_busy && dist_req_s ##1 ce && !dist_req_s && dist_busy) |=> dist_qdeny)
    else $error("clock channel accepted while busy");

  unit_quiescent_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && !unit_req_s[0] && unit_qaccept_n[0] && !unit_qdeny[0] && !quiescent_q[0])
    |=> unit_qdeny[0] && unit_qaccept_n[0])
    else $error("unit accepted without quiescent flag");

  unit_bus_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(unit_qaccept_n[0]) |-> (!unit_bus_en[0] && !$past(unit_bus_busy[0])))
    else $error("unit accepted with bus active");

  wake_output_a: assert property (@(posedge core_clk) disable iff (rst)
    unit_wake_active[0] |-> (wake_en_q[0] && !unit_bus_en[0]))
    else $error("wake output without bus idled");

  req_sync_depth_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce [*3]) |-> (dist_req_s == $past(dist_qreq_n, 2)))
    else $error("request not two-stage synchronised");

  pchan_absent_a: assert property (@(posedge core_clk) disable iff (rst)
    !MULTICHIP |-> (!p_accept && !p_isolated))
    else $error("P-Channel active in single-chip build");

endmodule

// >>> tb/dlp_far_model.sv
// Purpose: Far-side model, a memory responder plus the controller's wake resynchroniser
// Assumes: At most one read per ID outstanding
// Notes: Stalls one address cycle in four; idle ids toggle so stale values never match
module dlp_far_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Manager side
  input  wire logic       ax_valid,
  input  wire logic       ax_write,
  input  wire logic [3:0] ax_len,
  input  wire logic [1:0] ax_id,
  output logic            ax_ready,
  output logic            r_valid,
  output logic [1:0]      r_id,
  output logic            r_last,
  output logic            b_valid,
  output logic [1:0]      b_id,
  output logic            mem_idle,
  // Wake
  input  wire logic [3:0] unit_wake_active,
  output logic [3:0]      wake_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int         rem [4];
  int         ptr;
  int         k;
  logic [1:0] wq [$];
  logic [1:0] cyc;
  logic [3:0] wake_meta;

  always @(posedge core_clk or posedge rst)
    if (rst)
      {wake_seen, wake_meta} <= 8'h00;
    else
      {wake_seen, wake_meta} <= {wake_meta, unit_wake_active};

  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      rem = '{default: 0};
      ptr = 0;
      wq.delete();
      {cyc, ax_ready, r_valid, r_id, r_last, b_valid, b_id} <= 10'h000;
      mem_idle <= 1'b1;
    end
    else
    begin
      cyc <= cyc + 2'h1;
      ax_ready <= (cyc != 2'h3);
      if (ax_valid && ax_ready)
      begin
        if (ax_write)
          wq.push_back(ax_id);
        else
          rem[ax_id] = rem[ax_id] + ax_len + 1;
      end
      k = 0;
      while (k < 4 && rem[(ptr + k) % 4] == 0)
        k++;
      if (k < 4)
      begin
        k = (ptr + k) % 4;
        rem[k] = rem[k] - 1;
        r_valid <= 1'b1;
        r_id <= k[1:0];
        r_last <= (rem[k] == 0);
        ptr = k + 1;
      end
      else
      begin
        r_valid <= 1'b0;
        r_last <= 1'b0;
        r_id <= ~r_id;
      end
      if (wq.size() > 0)
      begin
        b_valid <= 1'b1;
        b_id <= wq.pop_front();
      end
      else
      begin
        b_valid <= 1'b0;
        b_id <= ~b_id;
      end
      mem_idle <= (rem[0] + rem[1] + rem[2] + rem[3] == 0) && (wq.size() == 0);
    end
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the distributor low-power block
// Assumes: Single-chip build, regular-only manager port
// Notes: Q requests land 13 ns after the edge, as an unsynchronised controller would
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, ce, reg_we, reg_re;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mreq_addr, ax_addr, seed;
  logic        dist_qreq_n, dist_qaccept_n, dist_qdeny, dist_clk_en, dist_busy;
  logic [3:0]  unit_qreq_n, unit_qaccept_n, unit_qdeny, unit_bus_busy, unit_bus_en;
  logic [3:0]  unit_msg_pending, unit_wake_active, wake_seen, mreq_len, ax_len;
  logic        p_req, p_state, p_accept, p_isolated, mem_idle;
  logic        mreq_valid, mreq_ready, mreq_write, mreq_cc, ax_valid, ax_ready, ax_write;
  logic [2:0]  mreq_size, ax_size;
  logic [1:0]  mreq_burst, mreq_id, ax_burst, ax_id, r_id, b_id;
  logic        r_valid, r_last, r_ready, b_valid, b_ready;
  logic [40:0] exp_q [$];
  logic [40:0] e;
  int          err_total, comparisons, i, m, n;

  dlp_top dlp_top_i (.core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .dist_qreq_n, .dist_qaccept_n, .dist_qdeny, .dist_clk_en, .dist_busy, .unit_qreq_n, .unit_qaccept_n,
    .unit_qdeny, .unit_bus_busy, .unit_bus_en, .unit_msg_pending, .unit_wake_active, .p_req, .p_state,
    .p_accept, .p_isolated, .mreq_valid, .mreq_ready, .mreq_write, .mreq_addr, .mreq_len, .mreq_size,
    .mreq_burst, .mreq_id, .mreq_cc, .ax_valid, .ax_ready, .ax_write, .ax_addr, .ax_len, .ax_size,
    .ax_burst, .ax_id, .r_valid, .r_id, .r_last, .r_ready, .b_valid, .b_id, .b_ready);
  dlp_far_model dlp_far_model_i (.core_clk, .rst, .ax_valid, .ax_write, .ax_len, .ax_id, .ax_ready,
    .r_valid, .r_id, .r_last, .b_valid, .b_id, .mem_idle, .unit_wake_active, .wake_seen);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [1:0] qans(input int u);
    return (u < 0) ? {~dist_qaccept_n, dist_qdeny} : {~unit_qaccept_n[u], unit_qdeny[u]};
  endfunction

  task automatic close_out();
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tmo(input string what);
    err_total++;
    $display("[ERR] %0t timeout on %s", $time, what);
    close_out();
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] x, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, x, what);
  endtask

  // One four-phase cycle; x is {accept, deny}
  task automatic qrun(input int u, input logic [1:0] x);
    int k;
    @(posedge core_clk);
    if (u < 0) dist_qreq_n <= #13 1'b0;
    else unit_qreq_n[u] <= #13 1'b0;
    for (k = 0; k < 8 && qans(u) == 2'h0; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (k == 8) tmo("q answer");
    repeat (3) @(posedge core_clk);
    #1;
    chk(qans(u), x, "q answer");
    chk(u < 0 ? dist_clk_en : unit_bus_en[u], x != 2'h2, "gate");
    @(posedge core_clk);
    if (u < 0) dist_qreq_n <= #13 1'b1;
    else unit_qreq_n[u] <= #13 1'b1;
    for (k = 0; k < 8 && qans(u) != 2'h0; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (k == 8) tmo("q withdraw");
  endtask

  task automatic mreq(input logic w, bt1, bt0, input logic [1:0] id, input logic cc, ok, mgr,
                      input logic [3:0] lfix, input logic rnd);
    int k;
    logic [3:0] l;
    logic [1:0] eb;
    seed = lfsr(seed);
    l = rnd ? (4'h1 << (seed[5:3] % 5)) - 4'h1 : lfix;
    eb = (!bt1 && !bt0 || bt1 && bt0) ? (mgr ? 2'h2 : 2'h1) : {bt1, bt0};
    if (eb == 2'h2 && l == 4'h0) eb = 2'h1;
    @(posedge core_clk);
    {mreq_valid, mreq_write, mreq_cc, mreq_len, mreq_size} <= {1'b1, w, cc, l, 3'h2};
    {mreq_burst, mreq_id, mreq_addr} <= {bt1, bt0, id, seed[31:2], 2'h0};
    for (k = 0; k < 40; k++)
    begin
      @(negedge core_clk);
      if (mreq_ready === 1'b1) break;
    end
    if (k == 40) tmo("request");
    @(posedge core_clk);
    mreq_valid <= 1'b0;
    if (ok) exp_q.push_back({w, seed[31:2], 2'h0, l, eb, id});
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 200 && !(exp_q.size() == 0 && mem_idle === 1'b1); k++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (k == 200) tmo("drain");
    chk({r_ready, b_ready}, 32'h3, "response ready");
    repeat (2) @(posedge core_clk);
    reg_rd(8'h14, 32'h0, "outstanding");
  endtask

  always @(posedge core_clk)
    if (!rst && ax_valid === 1'b1 && ax_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0, "unexpected address");
      else
      begin
        e = exp_q.pop_front();
        chk(ax_addr, e[39:8], "address");
        chk({ax_write, ax_size, ax_len, ax_burst, ax_id}, {e[40], 3'h2, e[7:0]}, "burst shape");
      end
    end

  initial
  begin
    {err_total, comparisons, seed, rst, ce} = {32'h0, 32'h0, 32'h4926, 2'h3};
    {reg_addr, reg_wdata, reg_we, reg_re, dist_busy, p_req, p_state} = '0;
    {mreq_valid, mreq_write, mreq_cc, mreq_addr, mreq_len, mreq_size, mreq_burst, mreq_id} = '0;
    {unit_bus_busy, unit_msg_pending, dist_qreq_n, unit_qreq_n} = 13'h001F;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    reg_rd(8'h00, 32'h0, "quiescent reset");
    reg_rd(8'h04, 32'h0, "wake enable reset");
    reg_rd(8'h0C, 32'hF, "bus enable reset");
    reg_rd(8'h3C, 32'h0, "unmapped");
    qrun(-1, 2'h2);
    @(posedge core_clk);
    dist_busy <= 1'b1;
    qrun(-1, 2'h1);
    @(posedge core_clk);
    dist_busy <= 1'b0;
    for (i = 0; i < 4; i++) qrun(i, 2'h1);
    reg_wr(8'h00, 32'hFFFF_FFFF);
    reg_rd(8'h00, 32'hF, "quiescent");
    unit_bus_busy <= 4'h4;
    qrun(2, 2'h1);
    unit_bus_busy <= 4'h0;
    for (i = 0; i < 4; i++) qrun(i, 2'h2);
    reg_wr(8'h04, 32'h2);
    #1;
    chk(unit_bus_en, 32'hD, "wake bus off");
    unit_msg_pending <= 4'h2;
    for (n = 0; n < 8 && wake_seen !== 4'h2; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (n == 8) tmo("wake");
    chk(unit_wake_active, 32'h2, "wake active");
    // power first, then restore programming, then reopen the unit channel
    reg_wr(8'h04, 32'h0);
    #1;
    chk({unit_bus_en, unit_wake_active}, 32'hF0, "wake restore");
    unit_msg_pending <= 4'h0;
    qrun(1, 2'h2);
    for (m = 0; m < 2; m++)
    begin
      reg_wr(8'h10, m);
      reg_rd(8'h10, m, "manager mode");
      for (i = 0; i < 8; i++)
      begin
        mreq(i[2], i[1], i[0], i[1:0], 1'b0, 1'b1, m[0], 4'h0, 1'b1);
        if (i[1:0] == 2'h3) drain();
      end
    end
    mreq(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 4'h2, 1'b0);
    reg_rd(8'h08, 32'h0008_0000, "irregular flag");
    mreq(1'b0, 1'b0, 1'b1, 2'h1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    reg_wr(8'h08, 32'h0008_0000);
    reg_rd(8'h08, 32'h0004_0000, "cross chip flag");
    {p_req, p_state} <= 2'h3;
    repeat (4) @(posedge core_clk);
    #1;
    chk({p_accept, p_isolated}, 32'h0, "isolation");
    chk(exp_q.size(), 32'h0, "missing requests");
    close_out();
  end
endmodule
